/* logic/zone_handoff_control.sv */
// Zone handoff controller: induct, two-zone accumulation, discharge and
// arrival-jam supervision, steered by a controller over AXI4-Lite.
// Assumes zone sensors are asynchronous pins (high = carton blocks it).
`default_nettype none
module zone_handoff_control #(
	parameter int ARRIVAL_WAIT_CYCLES = zone_handoff_pkg::ARRIVAL_WAIT_CYC
) (
	// Clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// AXI4-Lite write channels
	input wire logic [zone_handoff_pkg::ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [zone_handoff_pkg::DATA_W-1:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// AXI4-Lite read channels
	input wire logic [zone_handoff_pkg::ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [zone_handoff_pkg::DATA_W-1:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Zone sensors
	input wire logic up_sensor,
	input wire logic dn_sensor,
	// Motor and neighbour controls
	output logic up_motor,
	output logic dn_motor,
	output logic hold_up_nbr
);
	import zone_handoff_pkg::*;

	function automatic logic [WORD_W-1:0] inc(input logic [WORD_W-1:0] v);
		inc = v + 16'h0001;
	endfunction

	//////////////////////////////////////////////////////////////////////////
	// Bus state
	logic aw_have_q, aw_have_d, w_have_q, w_have_d, bvalid_q, bvalid_d, rvalid_q, rvalid_d;
	logic [ADDR_W-1:0] awaddr_q, awaddr_d;
	logic [DATA_W-1:0] wdata_q, wdata_d, rdata_q, rdata_d;
	logic [3:0] wstrb_q, wstrb_d;
	logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
	logic wr_go, wr_hit, rd_go;
	logic [WORD_W-1:0] wval;
	// Control registers
	logic [WORD_W-1:0] up_acc_q, up_acc_d, dn_acc_q, dn_acc_d, induct_q, induct_d, disch_q, disch_d;
	logic [WORD_W-1:0] ind1_q, ind1_d, ind2_q, ind2_d, set1_q, set1_d, set2_q, set2_d;
	logic single_q, single_d;
	// Zone state
	logic up_s1_q, up_s2_q, up_s3_q, dn_s1_q, dn_s2_q, dn_s3_q;
	logic [WORD_W-1:0] up_arr_q, up_arr_d, up_dep_q, up_dep_d, dn_arr_q, dn_arr_d, dn_dep_q, dn_dep_d;
	logic [WORD_W-1:0] up_rel_q, up_rel_d, dn_rel_q, dn_rel_d;
	logic up_pend_q, up_pend_d, dn_pend_q, dn_pend_d, ind_ok_q, ind_ok_d;
	logic [WORD_W-1:0] cur1_q, cur1_d, cur2_q, cur2_d, dc1_q, dc1_d, dc2_q, dc2_d;
	logic [WORD_W-1:0] fwd1_q, fwd1_d, fwd2_q, fwd2_d;
	logic jam_q, jam_d, flex_q, flex_d, trk_ok_q, trk_ok_d;
	logic up_motor_q, up_motor_d, dn_motor_q, dn_motor_d, hold_q, hold_d;
	disch_t dis_q, dis_d;
	logic [31:0] wait_q, wait_d;
	logic up_rise, up_fall, dn_rise, dn_fall, exit_fall, confirm;
	logic up_block, dn_block, dest_ok;

	//////////////////////////////////////////////////////////////////////////
	// Bus handshakes; write happens once both address and data are held
	always_comb begin
		aw_have_d = aw_have_q;
		w_have_d = w_have_q;
		awaddr_d = awaddr_q;
		wdata_d = wdata_q;
		wstrb_d = wstrb_q;
		bvalid_d = bvalid_q;
		bresp_d = bresp_q;
		rvalid_d = rvalid_q;
		rdata_d = rdata_q;
		rresp_d = rresp_q;
		if (s_axi_awvalid && !aw_have_q && !bvalid_q) begin
			aw_have_d = 1'b1;
			awaddr_d = s_axi_awaddr;
		end
		if (s_axi_wvalid && !w_have_q && !bvalid_q) begin
			w_have_d = 1'b1;
			wdata_d = s_axi_wdata;
			wstrb_d = s_axi_wstrb;
		end
		if (wr_go) begin
			aw_have_d = 1'b0;
			w_have_d = 1'b0;
			bvalid_d = 1'b1;
			bresp_d = wr_hit ? RESP_OKAY : RESP_SLVERR;
		end else if (bvalid_q && s_axi_bready) begin
			bvalid_d = 1'b0;
		end
		if (rd_go) begin
			rvalid_d = 1'b1;
			rresp_d = RESP_OKAY;
			rdata_d = '0;
			unique case (s_axi_araddr)
				OFF_UP_ACC: rdata_d[WORD_W-1:0] = up_acc_q;
				OFF_DN_ACC: rdata_d[WORD_W-1:0] = dn_acc_q;
				OFF_UP_REL: rdata_d[WORD_W-1:0] = up_rel_q;
				OFF_DN_REL: rdata_d[WORD_W-1:0] = dn_rel_q;
				OFF_INDUCT: rdata_d[WORD_W-1:0] = induct_q;
				OFF_DISCH: rdata_d[WORD_W-1:0] = disch_q;
				OFF_IND_TRK1: rdata_d[WORD_W-1:0] = ind1_q;
				OFF_IND_TRK2: rdata_d[WORD_W-1:0] = ind2_q;
				OFF_SET_TRK1: rdata_d[WORD_W-1:0] = set1_q;
				OFF_SET_TRK2: rdata_d[WORD_W-1:0] = set2_q;
				OFF_CUR_TRK1: rdata_d[WORD_W-1:0] = cur1_q;
				OFF_CUR_TRK2: rdata_d[WORD_W-1:0] = cur2_q;
				OFF_FWD_TRK1: rdata_d[WORD_W-1:0] = fwd1_q;
				OFF_FWD_TRK2: rdata_d[WORD_W-1:0] = fwd2_q;
				OFF_UP_CNT: rdata_d = {up_dep_q, up_arr_q};
				OFF_DN_CNT: rdata_d = {dn_dep_q, dn_arr_q};
				OFF_STATUS: begin
					rdata_d[ST_JAM] = jam_q;
					rdata_d[ST_FLEX] = flex_q;
					rdata_d[ST_TRK_OK] = trk_ok_q;
					rdata_d[ST_WAIT] = (dis_q != DIS_IDLE);
				end
				OFF_CONFIG: rdata_d[CFG_SINGLE] = single_q;
				default: rresp_d = RESP_SLVERR;
			endcase
		end else if (rvalid_q && s_axi_rready) begin
			rvalid_d = 1'b0;
		end
	end
	assign wr_go = aw_have_q && w_have_q && !bvalid_q;
	assign rd_go = s_axi_arvalid && !rvalid_q;
	assign wval = wdata_q[WORD_W-1:0];

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			aw_have_q <= 1'b0;
			w_have_q <= 1'b0;
			awaddr_q <= '0;
			wdata_q <= '0;
			wstrb_q <= '0;
			bvalid_q <= 1'b0;
			bresp_q <= RESP_OKAY;
			rvalid_q <= 1'b0;
			rdata_q <= '0;
			rresp_q <= RESP_OKAY;
		end else begin
			aw_have_q <= aw_have_d;
			w_have_q <= w_have_d;
			awaddr_q <= awaddr_d;
			wdata_q <= wdata_d;
			wstrb_q <= wstrb_d;
			bvalid_q <= bvalid_d;
			bresp_q <= bresp_d;
			rvalid_q <= rvalid_d;
			rdata_q <= rdata_d;
			rresp_q <= rresp_d;
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// Sensor synchronisers; stage 3 is the occupancy level, 2 versus 3 the edge
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			{up_s1_q, up_s2_q, up_s3_q} <= 3'h0;
			{dn_s1_q, dn_s2_q, dn_s3_q} <= 3'h0;
		end else begin
			{up_s1_q, up_s2_q, up_s3_q} <= {up_sensor, up_s1_q, up_s2_q};
			{dn_s1_q, dn_s2_q, dn_s3_q} <= {dn_sensor, dn_s1_q, dn_s2_q};
		end
	end
	assign up_rise = up_s2_q && !up_s3_q;
	assign up_fall = !up_s2_q && up_s3_q;
	assign dn_rise = dn_s2_q && !dn_s3_q;
	assign dn_fall = !dn_s2_q && dn_s3_q;
	assign exit_fall = single_q ? up_fall : dn_fall;
	assign confirm = (wr_go && awaddr_q == OFF_DISCH && wstrb_q[0] && wval == CODE_FULL)
		|| up_acc_q[ACC_ARRIVED];

	//////////////////////////////////////////////////////////////////////////
	// Zone run decisions
	// singulation: one carton per zone, release only into an empty zone
	assign up_block = up_acc_q[ACC_HOLD] && !up_pend_q;
	assign dn_block = dn_acc_q[ACC_HOLD] && !dn_pend_q;
	// exit held while confirming or downstream full
	assign dest_ok = single_q ? (disch_q == CODE_CLEAR && dis_q == DIS_IDLE)
		: (!dn_s3_q && !dn_acc_q[ACC_ADJ]);

	//////////////////////////////////////////////////////////////////////////
	// Registers written by the controller and zone tracking state
	always_comb begin
		up_acc_d = up_acc_q;
		dn_acc_d = dn_acc_q;
		induct_d = induct_q;
		disch_d = disch_q;
		ind1_d = ind1_q;
		ind2_d = ind2_q;
		set1_d = set1_q;
		set2_d = set2_q;
		single_d = single_q;
		up_pend_d = up_pend_q;
		dn_pend_d = dn_pend_q;
		up_rel_d = up_rel_q;
		dn_rel_d = dn_rel_q;
		ind_ok_d = ind_ok_q;
		up_arr_d = up_arr_q;
		up_dep_d = up_dep_q;
		dn_arr_d = dn_arr_q;
		dn_dep_d = dn_dep_q;
		cur1_d = cur1_q;
		cur2_d = cur2_q;
		dc1_d = dc1_q;
		dc2_d = dc2_q;
		fwd1_d = fwd1_q;
		fwd2_d = fwd2_q;
		flex_d = flex_q;
		trk_ok_d = trk_ok_q;
		jam_d = jam_q;
		dis_d = dis_q;
		wait_d = wait_q;
		wr_hit = 1'b1;
		// values persist until rewritten; low byte lanes carry the word
		if (wr_go && wstrb_q[1:0] == 2'h3) begin
			unique case (awaddr_q)
				OFF_UP_ACC: up_acc_d = wval;
				OFF_DN_ACC: dn_acc_d = wval;
				// only count plus one is a release request
				OFF_UP_REL: up_pend_d = up_pend_q || (wval == inc(up_rel_q));
				OFF_DN_REL: dn_pend_d = dn_pend_q || (wval == inc(dn_rel_q));
				OFF_INDUCT: begin
					induct_d = wval;
					// words valid on 4 to 1 change
					if (induct_q == CODE_ACCEPT && wval == CODE_CLEAR)
						ind_ok_d = 1'b1;
				end
				OFF_DISCH: disch_d = wval;
				OFF_IND_TRK1: ind1_d = wval;
				OFF_IND_TRK2: ind2_d = wval;
				OFF_SET_TRK1: set1_d = wval;
				OFF_SET_TRK2: set2_d = wval;
				OFF_STATUS: begin
					if (wdata_q[ST_JAM]) jam_d = 1'b0;
					if (wdata_q[ST_FLEX]) flex_d = 1'b0;
				end
				OFF_CONFIG: single_d = wdata_q[CFG_SINGLE];
				default: wr_hit = 1'b0;
			endcase
		end else if (wr_go) begin
			wr_hit = 1'b0;
		end
		if (up_rise) up_arr_d = inc(up_arr_q);
		if (up_fall) up_dep_d = inc(up_dep_q);
		if (dn_rise) dn_arr_d = inc(dn_arr_q);
		if (dn_fall) dn_dep_d = inc(dn_dep_q);
		// attach induct words at arrival only when valid
		if (up_rise) begin
			cur1_d = ind_ok_q ? ind1_q : dc1_q;
			cur2_d = ind_ok_q ? ind2_q : dc2_q;
			trk_ok_d = ind_ok_q;
			ind_ok_d = 1'b0;
			// long carton seen while still inducting
			if (induct_q == CODE_ACCEPT) flex_d = 1'b1;
		end
		// released carton carries rewritten words only on a count release
		if (up_fall && !single_q) begin
			dc1_d = up_pend_q ? set1_q : cur1_q;
			dc2_d = up_pend_q ? set2_q : cur2_q;
		end
		if (up_fall && up_pend_q) begin
			up_pend_d = 1'b0;
			up_rel_d = inc(up_rel_q);
		end
		if (dn_fall && dn_pend_q) begin
			dn_pend_d = 1'b0;
			dn_rel_d = inc(dn_rel_q);
		end
		// outgoing forward tracking when exit sensor clears
		if (exit_fall) begin
			fwd1_d = single_q ? (up_pend_q ? set1_q : cur1_q) : (dn_pend_q ? set1_q : dc1_q);
			fwd2_d = single_q ? (up_pend_q ? set2_q : cur2_q) : (dn_pend_q ? set2_q : dc2_q);
		end
		// arrival confirmation wait, jam when it times out
		unique case (dis_q)
			DIS_IDLE: if (exit_fall) begin
				dis_d = DIS_WAIT;
				wait_d = '0;
			end
			DIS_WAIT: if (confirm) begin
				dis_d = DIS_IDLE;
			end else if (wait_q == 32'(ARRIVAL_WAIT_CYCLES - 1)) begin
				dis_d = DIS_JAM;
				jam_d = 1'b1;
			end else begin
				wait_d = wait_q + 32'h0000_0001;
			end
			DIS_JAM: if (confirm) dis_d = DIS_IDLE;
		endcase
	end

	always_comb begin
		up_motor_d = (induct_q == CODE_ACCEPT) || (up_s3_q && !up_block && dest_ok);
		dn_motor_d = !single_q && dn_s3_q && !dn_block && disch_q == CODE_CLEAR && dis_q == DIS_IDLE;
		hold_d = up_acc_q[ACC_ADJ] || up_s3_q;
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			up_acc_q <= CODE_RST;
			dn_acc_q <= CODE_RST;
			induct_q <= CODE_RST;
			disch_q <= CODE_RST;
			{ind1_q, ind2_q, set1_q, set2_q} <= '0;
			single_q <= 1'b0;
			{up_pend_q, dn_pend_q, ind_ok_q} <= 3'h0;
			{up_rel_q, dn_rel_q} <= '0;
			{up_arr_q, up_dep_q, dn_arr_q, dn_dep_q} <= '0;
			{cur1_q, cur2_q, dc1_q, dc2_q, fwd1_q, fwd2_q} <= '0;
			{flex_q, trk_ok_q, jam_q} <= 3'h0;
			dis_q <= DIS_IDLE;
			wait_q <= '0;
			{up_motor_q, dn_motor_q, hold_q} <= 3'h0;
		end else begin
			up_acc_q <= up_acc_d;
			dn_acc_q <= dn_acc_d;
			induct_q <= induct_d;
			disch_q <= disch_d;
			{ind1_q, ind2_q, set1_q, set2_q} <= {ind1_d, ind2_d, set1_d, set2_d};
			single_q <= single_d;
			{up_pend_q, dn_pend_q, ind_ok_q} <= {up_pend_d, dn_pend_d, ind_ok_d};
			{up_rel_q, dn_rel_q} <= {up_rel_d, dn_rel_d};
			{up_arr_q, up_dep_q, dn_arr_q, dn_dep_q} <= {up_arr_d, up_dep_d, dn_arr_d, dn_dep_d};
			{cur1_q, cur2_q, dc1_q, dc2_q, fwd1_q, fwd2_q} <= {cur1_d, cur2_d, dc1_d, dc2_d, fwd1_d, fwd2_d};
			{flex_q, trk_ok_q, jam_q} <= {flex_d, trk_ok_d, jam_d};
			dis_q <= dis_d;
			wait_q <= wait_d;
			{up_motor_q, dn_motor_q, hold_q} <= {up_motor_d, dn_motor_d, hold_d};
		end
	end

	// Outputs from flops; the bus ready outputs are decoded from the handshake flops
	assign s_axi_awready = !aw_have_q && !bvalid_q;
	assign s_axi_wready = !w_have_q && !bvalid_q;
	assign s_axi_bvalid = bvalid_q;
	assign s_axi_bresp = bresp_q;
	assign s_axi_arready = !rvalid_q;
	assign s_axi_rvalid = rvalid_q;
	assign s_axi_rdata = rdata_q;
	assign s_axi_rresp = rresp_q;
	assign up_motor = up_motor_q;
	assign dn_motor = dn_motor_q;
	assign hold_up_nbr = hold_q;

	//////////////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);

	property p_induct_run;
		induct_q == CODE_ACCEPT |=> up_motor_q;
	endproperty
	a_induct_run: assert property (p_induct_run) else $error("induct 4 did not run upstream zone");
	property p_ind_valid;
		wr_go && awaddr_q == OFF_INDUCT && wstrb_q[1:0] == 2'h3 && induct_q == CODE_ACCEPT
			&& wval == CODE_CLEAR && !up_rise |=> ind_ok_q;
	endproperty
	a_ind_valid: assert property (p_ind_valid) else $error("4 to 1 change did not validate words");
	property p_flex;
		up_rise && induct_q == CODE_ACCEPT |=> flex_q && up_motor_q;
	endproperty
	a_flex: assert property (p_flex) else $error("flex zone not flagged");
	property p_full_hold;
		disch_q != CODE_CLEAR |=> !dn_motor_q;
	endproperty
	a_full_hold: assert property (p_full_hold) else $error("exit released while downstream full");
	property p_clear_run;
		!single_q && dn_s3_q && !dn_acc_q[ACC_HOLD] && disch_q == CODE_CLEAR && dis_q == DIS_IDLE |=> dn_motor_q;
	endproperty
	a_clear_run: assert property (p_clear_run) else $error("exit not released when clear");
	property p_fwd_trk;
		exit_fall && !single_q && !dn_pend_q |=> fwd1_q == $past(dc1_q) && fwd2_q == $past(dc2_q);
	endproperty
	a_fwd_trk: assert property (p_fwd_trk) else $error("forward tracking not loaded");
	property p_jam;
		dis_q == DIS_WAIT && wait_q == 32'(ARRIVAL_WAIT_CYCLES - 1) && !confirm |=> jam_q && dis_q == DIS_JAM;
	endproperty
	a_jam: assert property (p_jam) else $error("arrival jam not raised");
	property p_wait_hold;
		dis_q != DIS_IDLE |=> !dn_motor_q;
	endproperty
	a_wait_hold: assert property (p_wait_hold) else $error("released while awaiting confirmation");
	property p_adj;
		!single_q && dn_acc_q[ACC_ADJ] && induct_q != CODE_ACCEPT |=> !up_motor_q;
	endproperty
	a_adj: assert property (p_adj) else $error("adjacent zone did not accumulate");
	property p_nbr_hold;
		up_acc_q[ACC_ADJ] |=> hold_q;
	endproperty
	a_nbr_hold: assert property (p_nbr_hold) else $error("upstream neighbour not held");
	property p_counts;
		up_s3_q |-> up_arr_q != up_dep_q;
	endproperty
	a_counts: assert property (p_counts) else $error("counts equal while occupied");

	c_jam: cover property (dis_q == DIS_WAIT ##1 dis_q == DIS_JAM);
	c_confirm: cover property (dis_q == DIS_WAIT ##1 dis_q == DIS_IDLE);
	c_induct: cover property (ind_ok_q ##1 up_rise);
	c_release: cover property (up_pend_q && up_fall);
endmodule
`default_nettype wire

/* logic/zone_handoff_pkg.sv */
// Package for the zone handoff controller: register map, field positions,
// status codes, reset values, timing constants and state types.
// Assumes a 100 MHz system clock and a 32-bit AXI4-Lite register bus.
`default_nettype none
package zone_handoff_pkg;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam int WORD_W = 16;
	// Register byte offsets
	localparam logic [ADDR_W-1:0] OFF_UP_ACC = 8'h00;
	localparam logic [ADDR_W-1:0] OFF_DN_ACC = 8'h04;
	localparam logic [ADDR_W-1:0] OFF_UP_REL = 8'h08;
	localparam logic [ADDR_W-1:0] OFF_DN_REL = 8'h0C;
	localparam logic [ADDR_W-1:0] OFF_INDUCT = 8'h10;
	localparam logic [ADDR_W-1:0] OFF_DISCH = 8'h14;
	localparam logic [ADDR_W-1:0] OFF_IND_TRK1 = 8'h18;
	localparam logic [ADDR_W-1:0] OFF_IND_TRK2 = 8'h1C;
	localparam logic [ADDR_W-1:0] OFF_SET_TRK1 = 8'h20;
	localparam logic [ADDR_W-1:0] OFF_SET_TRK2 = 8'h24;
	localparam logic [ADDR_W-1:0] OFF_CUR_TRK1 = 8'h28;
	localparam logic [ADDR_W-1:0] OFF_CUR_TRK2 = 8'h2C;
	localparam logic [ADDR_W-1:0] OFF_FWD_TRK1 = 8'h30;
	localparam logic [ADDR_W-1:0] OFF_FWD_TRK2 = 8'h34;
	localparam logic [ADDR_W-1:0] OFF_UP_CNT = 8'h38;
	localparam logic [ADDR_W-1:0] OFF_DN_CNT = 8'h3C;
	localparam logic [ADDR_W-1:0] OFF_STATUS = 8'h40;
	localparam logic [ADDR_W-1:0] OFF_CONFIG = 8'h44;
	// Accumulation control bits
	localparam int ACC_HOLD = 0;
	localparam int ACC_ADJ = 8;
	localparam int ACC_ARRIVED = 9;
	// Status bits and config bits
	localparam int ST_JAM = 0;
	localparam int ST_FLEX = 1;
	localparam int ST_TRK_OK = 2;
	localparam int ST_WAIT = 3;
	localparam int CFG_SINGLE = 0;
	// Handshake status codes
	localparam logic [WORD_W-1:0] CODE_CLEAR = 16'h0001;
	localparam logic [WORD_W-1:0] CODE_ACCEPT = 16'h0004;
	localparam logic [WORD_W-1:0] CODE_FULL = 16'h0005;
	localparam logic [WORD_W-1:0] CODE_RST = 16'h0000;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// Arrival confirmation window
	localparam int CLK_MHZ = 100;
	localparam int ARRIVAL_WAIT_MS = 5;
	localparam int ARRIVAL_WAIT_CYC = ARRIVAL_WAIT_MS * CLK_MHZ * 1000;
	typedef enum logic [1:0] {DIS_IDLE, DIS_WAIT, DIS_JAM} disch_t;
endpackage
`default_nettype wire

/* testbench/conveyor_model.sv */
// Carton model for a two-zone section: drops a carton on the upstream
// sensor on demand and moves it on while the zone motors keep running.
// Assumes the bench clock and that the bench commands each new carton.
`default_nettype none
module conveyor_model #(
	parameter int TRAVEL = 8
) (
	// Clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// Bench command and motor drives
	input wire logic load_up,
	input wire logic up_motor,
	input wire logic dn_motor,
	// Zone sensors, high while a carton blocks them
	output logic up_sensor,
	output logic dn_sensor
);
	timeunit 1ns;
	timeprecision 1ns;
	int up_cnt;
	int dn_cnt;
	////////////////////////////////////////////////////////////////////////
	// carton within zone
	// A carton only moves on after a full travel time of uninterrupted motor
	// run, and never into an occupied zone, so a stalled motor holds it
	always @(posedge clk) begin
		if (sys_rst) begin
			up_sensor <= 1'b0;
			dn_sensor <= 1'b0;
			up_cnt <= 0;
			dn_cnt <= 0;
		end else begin
			if (load_up) begin
				up_sensor <= 1'b1;
			end
			up_cnt <= (up_sensor && up_motor && !dn_sensor) ? up_cnt + 1 : 0;
			dn_cnt <= (dn_sensor && dn_motor) ? dn_cnt + 1 : 0;
			if (up_cnt == TRAVEL) begin
				up_sensor <= 1'b0;
				dn_sensor <= 1'b1;
			end
			if (dn_cnt == TRAVEL) begin
				dn_sensor <= 1'b0;
			end
		end
	end
endmodule
`default_nettype wire

/* testbench/zone_handoff_control_test.sv */
// Self-checking bench: register tasks on AXI4-Lite drive induct, release,
// discharge and divert sequences against the carton model.
// Assumes a 20-cycle arrival window so the jam shows up quickly.
`default_nettype none
module zone_handoff_control_test;
	timeunit 1ns;
	timeprecision 1ns;
	import zone_handoff_pkg::*;
	logic clk, sys_rst, aw_v, aw_r, w_v, w_r, b_v, b_r, ar_v, ar_r, r_v, r_r;
	logic up_s, dn_s, up_m, dn_m, hold, load;
	logic [7:0] aw_a, ar_a;
	logic [31:0] w_d, r_d;
	logic [1:0] b_resp, r_resp;
	int num_errors = 0;
	int n_compared = 0;
	zone_handoff_control #(.ARRIVAL_WAIT_CYCLES(20)) zone_handoff_control_inst (
		.clk(clk), .sys_rst(sys_rst), .s_axi_awaddr(aw_a), .s_axi_awvalid(aw_v), .s_axi_awready(aw_r),
		.s_axi_wdata(w_d), .s_axi_wstrb(4'hF), .s_axi_wvalid(w_v), .s_axi_wready(w_r),
		.s_axi_bresp(b_resp), .s_axi_bvalid(b_v), .s_axi_bready(b_r), .s_axi_araddr(ar_a),
		.s_axi_arvalid(ar_v), .s_axi_arready(ar_r), .s_axi_rdata(r_d), .s_axi_rresp(r_resp),
		.s_axi_rvalid(r_v), .s_axi_rready(r_r), .up_sensor(up_s), .dn_sensor(dn_s),
		.up_motor(up_m), .dn_motor(dn_m), .hold_up_nbr(hold));
	conveyor_model #(.TRAVEL(40)) conveyor_model_inst (.clk(clk), .sys_rst(sys_rst), .load_up(load),
		.up_motor(up_m), .dn_motor(dn_m), .up_sensor(up_s), .dn_sensor(dn_s));
	////////////////////////////////////////////////////////////////////////
	// Compare, verdict and bus tasks
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		n_compared++;
		if (s !== e) begin
			num_errors++;
			$display("[FAIL] %0t seen %h expected %h", $time, s, e);
		end
	endtask
	task automatic finish_test;
		if (num_errors == 0 && n_compared > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	// Ready is decoded from flops only, so it is looked at mid-cycle and acted on at the next edge
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = 2'h0);
		logic da, dw, ta, tw;
		da = 1'b0;
		dw = 1'b0;
		@(posedge clk);
		aw_a <= a;
		w_d <= d;
		aw_v <= 1'b1;
		w_v <= 1'b1;
		b_r <= 1'b1;
		while (!(da && dw)) begin
			@(negedge clk);
			ta = aw_r && !da;
			tw = w_r && !dw;
			@(posedge clk);
			if (ta) begin
				aw_v <= 1'b0;
				da = 1'b1;
			end
			if (tw) begin
				w_v <= 1'b0;
				dw = 1'b1;
			end
		end
		do @(negedge clk); while (b_v !== 1'b1);
		chk(32'(b_resp), 32'(er));
		@(posedge clk);
		b_r <= 1'b0;
		// Registered outputs move on this edge; look at them once settled
		@(negedge clk);
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] d, input logic [1:0] er = 2'h0);
		@(posedge clk);
		ar_a <= a;
		ar_v <= 1'b1;
		r_r <= 1'b1;
		do @(negedge clk); while (ar_r !== 1'b1);
		@(posedge clk);
		ar_v <= 1'b0;
		do @(negedge clk); while (r_v !== 1'b1);
		d = r_d;
		chk(32'(r_resp), 32'(er));
		@(posedge clk);
		r_r <= 1'b0;
	endtask
	task automatic rc(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] d;
		rd(a, d);
		chk(d, e);
	endtask
	task automatic feed;
		@(posedge clk);
		load <= 1'b1;
		@(posedge clk);
		load <= 1'b0;
		repeat (8) @(posedge clk);
	endtask
	////////////////////////////////////////////////////////////////////////
	// Clock and watchdog
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	initial begin
		repeat (20000) @(posedge clk);
		num_errors++;
		finish_test;
	end
	////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		logic [31:0] v;
		sys_rst = 1'b1;
		{aw_v, w_v, b_r, ar_v, r_r, load} = 6'h0;
		aw_a = 8'h0;
		ar_a = 8'h0;
		w_d = 32'h0;
		repeat (20) @(posedge clk);
		sys_rst <= 1'b0;
		// Persistence, neighbour hold and unmapped access
		wr(OFF_UP_ACC, 32'h100);
		rc(OFF_UP_ACC, 32'h100);
		chk(32'(hold), 32'h1);
		rd(8'h80, v, RESP_SLVERR);
		chk(v, 32'h0);
		wr(8'h80, 32'h1, RESP_SLVERR);
		wr(OFF_UP_ACC, 32'h0);
		// Carton reaches the zone while induct still accepts: flex, no words
		wr(OFF_IND_TRK1, 32'hA1);
		wr(OFF_INDUCT, 32'(CODE_ACCEPT));
		chk(32'(up_m), 32'h1);
		chk(32'(hold), 32'h0);
		wr(OFF_UP_ACC, 32'h1);
		feed;
		wr(OFF_INDUCT, 32'(CODE_CLEAR));
		rd(OFF_STATUS, v);
		chk(v & 32'h2, 32'h2);
		rc(OFF_CUR_TRK1, 32'h0);
		chk(32'(up_m), 32'h0);
		wr(OFF_STATUS, 32'h2);
		// Release by count while the adjacent zone is held, discharge full
		wr(OFF_DN_ACC, 32'h100);
		wr(OFF_SET_TRK1, 32'h5E1);
		wr(OFF_SET_TRK2, 32'h5E2);
		wr(OFF_DISCH, 32'(CODE_FULL));
		rd(OFF_UP_REL, v);
		wr(OFF_UP_REL, v + 32'h1);
		repeat (50) @(posedge clk);
		chk(32'(up_s), 32'h1);
		wr(OFF_DN_ACC, 32'h0);
		while (dn_s !== 1'b1) @(posedge clk);
		repeat (8) @(posedge clk);
		rc(OFF_UP_CNT, 32'h0001_0001);
		rc(OFF_DN_CNT, 32'h0000_0001);
		chk(32'(dn_m), 32'h0);
		// Discharge, forward words, arrival jam and divert confirmation
		wr(OFF_DISCH, 32'(CODE_CLEAR));
		chk(32'(dn_m), 32'h1);
		while (dn_s !== 1'b0) @(posedge clk);
		repeat (6) @(posedge clk);
		rc(OFF_FWD_TRK1, 32'h5E1);
		rc(OFF_FWD_TRK2, 32'h5E2);
		rd(OFF_STATUS, v);
		chk(v & 32'h8, 32'h8);
		repeat (30) @(posedge clk);
		rd(OFF_STATUS, v);
		chk(v & 32'h9, 32'h9);
		wr(OFF_UP_ACC, 32'h201);
		rd(OFF_STATUS, v);
		chk(v & 32'h8, 32'h0);
		wr(OFF_UP_ACC, 32'h1);
		wr(OFF_STATUS, 32'h1);
		rd(OFF_STATUS, v);
		chk(v & 32'h1, 32'h0);
		// Proper induct hands its words to the arriving carton
		wr(OFF_INDUCT, 32'(CODE_ACCEPT));
		wr(OFF_IND_TRK1, 32'h1D1);
		wr(OFF_IND_TRK2, 32'h1D2);
		wr(OFF_INDUCT, 32'(CODE_CLEAR));
		feed;
		rc(OFF_CUR_TRK1, 32'h1D1);
		rc(OFF_CUR_TRK2, 32'h1D2);
		rd(OFF_STATUS, v);
		chk(v & 32'h4, 32'h4);
		chk(32'(up_m), 32'h0);
		rc(OFF_UP_CNT, 32'h0001_0002);
		wr(OFF_UP_ACC, 32'h0);
		chk(32'(up_m), 32'h1);
		finish_test;
	end
endmodule
`default_nettype wire
